// ---- cffr_flag_response.sv ----
`timescale 1ns/1ns
module cffr_flag_response
    import cffr_pkg::*;
#(
    parameter int INT_PULSE = INT_PULSE_CYC,
    parameter int FIRST_WAKE = FIRST_WAKE_CYC,
    parameter int SECOND_WAKE = SECOND_WAKE_CYC,
    parameter int RESET_WARN = RESET_WARN_CYC
) (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic sys_rst,
    // Raw status bits from the analog and timer blocks
    input wire logic [STAT_W-1:0] statusRaw,
    // Pins and supplies
    input wire logic manualResetButtonN,
    input wire logic vinValid,
    input wire logic chargeEnablePinN,
    input wire logic dieOvertempShutdown,
    // Serial bus side
    input wire logic hostReadClear,
    input wire logic regulatorEnableReq,
    // Flags and interrupt
    output logic [FLAG_W-1:0] flags,
    output logic intN,
    // Response controls
    output logic chargeEnable,
    output logic vregReduced,
    output logic safetyTimerRun,
    output logic safetyTimerReset,
    output logic regulatorEnable,
    output logic systemRailEnable,
    output logic systemRailFromInput
);

    // ---------------------------------------------------------------
    // Input synchronisation
    // ---------------------------------------------------------------
    logic [STAT_W-1:0] statLvl, statRise;
    logic [MISC_W-1:0] miscRaw, miscLvl, miscRise, miscFall;

    assign miscRaw = {dieOvertempShutdown, chargeEnablePinN, vinValid,
                      manualResetButtonN};

    cffr_sync_edge #(.W(STAT_W)) uStat (
        .clk_sys(clk_sys),
        .sys_rst(sys_rst),
        .rawIn(statusRaw),
        .level(statLvl),
        .rise(statRise),
        .fall()
    );

    cffr_sync_edge #(.W(MISC_W), .RST_VAL(MISC_RST)) uMisc (
        .clk_sys(clk_sys),
        .sys_rst(sys_rst),
        .rawIn(miscRaw),
        .level(miscLvl),
        .rise(miscRise),
        .fall(miscFall)
    );

    logic buttonHeld, vinOk, ceActive, dieHot, supplyToggle;
    assign buttonHeld = ~miscLvl[MSC_BUTTON_N];
    assign vinOk = miscLvl[MSC_VIN];
    assign ceActive = ~miscLvl[MSC_CE_N];
    assign dieHot = miscLvl[MSC_DIE_OT];
    // Either edge of supply or enable pin counts as a toggle
    assign supplyToggle = miscRise[MSC_VIN] | miscFall[MSC_VIN] |
                          miscRise[MSC_CE_N] | miscFall[MSC_CE_N];

    // ---------------------------------------------------------------
    // Button hold timer
    // ---------------------------------------------------------------
    localparam logic [CNT_W-1:0] WAKE1_C = CNT_W'(FIRST_WAKE);
    localparam logic [CNT_W-1:0] WAKE2_C = CNT_W'(SECOND_WAKE);
    localparam logic [CNT_W-1:0] WARN_C = CNT_W'(RESET_WARN);

    logic [CNT_W-1:0] holdCnt_q, holdCnt_d;
    logic [2:0] btnStat_q, btnStat_d;
    logic [2:0] btnRise;

    always_comb begin
        holdCnt_d = holdCnt_q;
        if (!buttonHeld) begin
            holdCnt_d = CNT_RST;
        end else if (holdCnt_q < WARN_C) begin
            // Saturates so a long press gives one edge per threshold
            holdCnt_d = holdCnt_q + 24'h000001;
        end
        btnStat_d[0] = buttonHeld && (holdCnt_q >= WAKE1_C);
        btnStat_d[1] = buttonHeld && (holdCnt_q >= WAKE2_C);
        btnStat_d[2] = buttonHeld && (holdCnt_q >= WARN_C);
    end

    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            holdCnt_q <= CNT_RST;
            btnStat_q <= 3'h0;
        end else begin
            holdCnt_q <= holdCnt_d;
            btnStat_q <= btnStat_d;
        end
    end

    assign btnRise = btnStat_d & ~btnStat_q;

    // ---------------------------------------------------------------
    // Flag latches
    // ---------------------------------------------------------------
    logic [FLAG_W-1:0] flags_q, flags_d;
    logic [FLAG_W-1:0] setVec, clrVec;
    logic capPinFault_q, capPinFault_d;
    logic anyRise;

    // Rising edges only; falling edges set nothing
    assign setVec = {btnRise, statRise};
    assign anyRise = |setVec;

    always_comb begin
        clrVec = '0;
        if (hostReadClear) begin
            clrVec = ~(FLAG_W'(1) << FLG_TIMER);
        end
        if (supplyToggle) begin
            clrVec[FLG_TIMER] = 1'b1;
        end
        // Set wins over a clear in the same cycle
        flags_d = (flags_q & ~clrVec) | setVec;
        // Only a power-on reset releases the cap pin fault
        capPinFault_d = capPinFault_q | statRise[FLG_CAP_PIN_OPEN];
    end

    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            flags_q <= FLAGS_RST;
            capPinFault_q <= 1'b0;
        end else begin
            flags_q <= flags_d;
            capPinFault_q <= capPinFault_d;
        end
    end

    // ---------------------------------------------------------------
    // Interrupt pulse
    // ---------------------------------------------------------------
    localparam logic [CNT_W-1:0] PULSE_C = CNT_W'(INT_PULSE);

    logic [CNT_W-1:0] pulseCnt_q, pulseCnt_d;
    logic intN_q, intN_d;

    always_comb begin
        pulseCnt_d = pulseCnt_q;
        if (anyRise) begin
            // A new event restarts the pulse rather than queueing
            pulseCnt_d = PULSE_C;
        end else if (pulseCnt_q != CNT_RST) begin
            pulseCnt_d = pulseCnt_q - 24'h000001;
        end
        intN_d = (pulseCnt_d == CNT_RST);
    end

    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            pulseCnt_q <= CNT_RST;
            intN_q <= 1'b1;
        end else begin
            pulseCnt_q <= pulseCnt_d;
            intN_q <= intN_d;
        end
    end

    // ---------------------------------------------------------------
    // Fault response
    // ---------------------------------------------------------------
    logic chargeEn_q, chargeEn_d;
    logic vregRed_q, vregRed_d;
    logic timerRun_q, timerRun_d;
    logic timerRst_q, timerRst_d;
    logic regEn_q, regEn_d;
    logic railEn_q, railEn_d;
    logic railIn_q, railIn_d;
    logic pauseZone;

    assign pauseZone = statLvl[FLG_HOT] | statLvl[FLG_TH_OPEN];

    always_comb begin
        chargeEn_d = ceActive && !pauseZone && !flags_q[FLG_TIMER] &&
                     !capPinFault_q && !dieHot;
        vregRed_d = statLvl[FLG_WARM];
        timerRun_d = ceActive && !pauseZone &&
                     !flags_q[FLG_TIMER] && !capPinFault_q && !dieHot;
        // One-cycle timer reset once the fault flag has dropped
        timerRst_d = flags_q[FLG_TIMER] && !flags_d[FLG_TIMER];
        // Overcurrent leaves the regulator to the host
        regEn_d = regulatorEnableReq && !dieHot;
        railEn_d = !dieHot;
        railIn_d = vinOk && (statLvl[FLG_WARM] || statLvl[FLG_HOT] ||
                   flags_q[FLG_TIMER]);
    end

    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            chargeEn_q <= 1'b0;
            vregRed_q <= 1'b0;
            timerRun_q <= 1'b0;
            timerRst_q <= 1'b0;
            regEn_q <= 1'b0;
            railEn_q <= 1'b0;
            railIn_q <= 1'b0;
        end else begin
            chargeEn_q <= chargeEn_d;
            vregRed_q <= vregRed_d;
            timerRun_q <= timerRun_d;
            timerRst_q <= timerRst_d;
            regEn_q <= regEn_d;
            railEn_q <= railEn_d;
            railIn_q <= railIn_d;
        end
    end

    assign flags = flags_q;
    assign intN = intN_q;
    assign chargeEnable = chargeEn_q;
    assign vregReduced = vregRed_q;
    assign safetyTimerRun = timerRun_q;
    assign safetyTimerReset = timerRst_q;
    assign regulatorEnable = regEn_q;
    assign systemRailEnable = railEn_q;
    assign systemRailFromInput = railIn_q;

    // ---------------------------------------------------------------
    // Checks
    // ---------------------------------------------------------------
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (sys_rst);

    a_rise_sets_flag: assert property (
        anyRise |=> ((flags_q & $past(setVec)) == $past(setVec)))
        else $error("rising status did not set its flag");

    a_int_low_pulse: assert property (
        anyRise |=> !intN_q [*8])
        else $error("interrupt pulse missing or too short");

    a_fall_no_int: assert property (
        (pulseCnt_q == CNT_RST) && !anyRise |=> intN_q)
        else $error("interrupt without a rising edge");

    a_hot_pause: assert property (
        statLvl[FLG_HOT] |=> !chargeEn_q && !timerRun_q)
        else $error("hot zone did not pause charging");

    a_open_pause: assert property (
        statLvl[FLG_TH_OPEN] |=> !chargeEn_q && !timerRun_q)
        else $error("open thermistor did not pause charging");

    a_warm_vreg: assert property (
        statLvl[FLG_WARM] |=> vregRed_q)
        else $error("warm zone did not reduce regulation voltage");

    a_rail_input: assert property (
        vinOk && (statLvl[FLG_WARM] || flags_q[FLG_TIMER]) |=> railIn_q)
        else $error("system rail not sourced from input");

    a_timer_hold: assert property (
        flags_q[FLG_TIMER] && !supplyToggle |=>
        flags_q[FLG_TIMER] && !chargeEn_q)
        else $error("timer fault released without toggle");

    a_timer_reset: assert property (
        $fell(flags_q[FLG_TIMER]) |-> timerRst_q ##1 !timerRst_q)
        else $error("safety timer not reset after fault clear");

    a_cap_latched: assert property (
        capPinFault_q |=> capPinFault_q && !chargeEn_q)
        else $error("cap pin fault released before reset");

    a_read_clears: assert property (
        hostReadClear && !anyRise |=>
        ((flags_q & ~(FLAG_W'(1) << FLG_TIMER)) == '0))
        else $error("host read did not clear flags");

    a_ocp_reg_on: assert property (
        regulatorEnableReq && !dieHot |=> regEn_q)
        else $error("regulator dropped on overcurrent");

    a_die_shutdown: assert property (
        dieHot && !anyRise |=> !chargeEn_q && !timerRun_q && !regEn_q &&
        !railEn_q && ((flags_q & ~$past(flags_q)) == '0))
        else $error("die shutdown response wrong");

    c_hot_event: cover property (statRise[FLG_HOT] ##1 !intN_q);
    c_timer_cycle: cover property (flags_q[FLG_TIMER] ##[1:50] timerRst_q);
    c_button_warn: cover property (btnRise[2]);
    c_read_clear: cover property (hostReadClear && |flags_q);

endmodule : cffr_flag_response

// ---- cffr_flag_response_tb.sv ----
`timescale 1ns/1ns
module cffr_flag_response_tb
    import cffr_pkg::*;
;
    localparam int PULSE = 20;
    typedef struct {int pos; logic ce; logic run; logic vr;} cffr_row_s;
    // Column order: flag position, charge, timer run, reduced voltage
    cffr_row_s rows[10] = '{'{0, 1, 1, 1}, '{1, 0, 0, 0}, '{2, 1, 1, 0},
        '{3, 1, 1, 0}, '{4, 1, 1, 0}, '{5, 1, 1, 0}, '{6, 1, 1, 0},
        '{7, 0, 0, 0}, '{8, 1, 1, 0}, '{10, 1, 1, 0}};
    logic clk_sys, sysRst, readReq, regOn;
    logic [STAT_W-1:0] statusRaw;
    logic buttonN, vinValid, cePinN, dieOt, hostReadClear, regReq;
    logic [FLAG_W-1:0] flags, readFlags, expFlags;
    logic intN, chargeEnable, vregReduced, timerRun, timerReset;
    logic regulatorEnable, railEnable, railFromInput, seen;
    int n_mismatch, samples_checked, b, cnt;

    cffr_flag_response #(.INT_PULSE(PULSE), .FIRST_WAKE(30),
        .SECOND_WAKE(60), .RESET_WARN(100)) dut_u (
        .clk_sys(clk_sys), .sys_rst(sysRst), .statusRaw(statusRaw),
        .manualResetButtonN(buttonN), .vinValid(vinValid),
        .chargeEnablePinN(cePinN), .dieOvertempShutdown(dieOt),
        .hostReadClear(hostReadClear), .regulatorEnableReq(regReq),
        .flags(flags), .intN(intN), .chargeEnable(chargeEnable),
        .vregReduced(vregReduced), .safetyTimerRun(timerRun),
        .safetyTimerReset(timerReset), .regulatorEnable(regulatorEnable),
        .systemRailEnable(railEnable), .systemRailFromInput(railFromInput));

    cffr_host_model host_u (.clk_sys(clk_sys), .sys_rst(sysRst),
        .readReq(readReq), .regOn(regOn), .flags(flags),
        .hostReadClear(hostReadClear), .regulatorEnableReq(regReq),
        .readFlags(readFlags));

    // ----------------------------------------
    // Helpers
    // ----------------------------------------
    initial begin
        clk_sys = 1'b0;
        forever #4 clk_sys = ~clk_sys;
    end

    task automatic waitCyc(input int n);
        repeat (n) @(negedge clk_sys);
    endtask : waitCyc

    task automatic cmpBit(input string name, input logic exp, input logic got);
        samples_checked++;
        if (got !== exp) begin
            n_mismatch++;
            $display("[ERR] %s expected %b seen %b", name, exp, got);
        end
    endtask : cmpBit

    task automatic cmpVec(input string name, input logic [FLAG_W-1:0] exp,
                          input logic [FLAG_W-1:0] got);
        samples_checked++;
        if (got !== exp) begin
            n_mismatch++;
            $display("[ERR] %s expected %h seen %h", name, exp, got);
        end
    endtask : cmpVec

    task automatic hostRead();
        readReq = 1'b1;
        waitCyc(1);
        readReq = 1'b0;
        waitCyc(2);
    endtask : hostRead

    task automatic complete_run();
        $display("checks %0d mismatches %0d", samples_checked, n_mismatch);
        if (n_mismatch == 0 && samples_checked > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask : complete_run

    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    initial begin
        n_mismatch = 0;
        samples_checked = 0;
        sysRst = 1'b1;
        readReq = 1'b0;
        regOn = 1'b0;
        statusRaw = '0;
        buttonN = 1'b1;
        vinValid = 1'b1;
        cePinN = 1'b0;
        dieOt = 1'b0;
        waitCyc(2);
        cmpVec("flagsRst", 15'h0000, flags);
        cmpBit("intNRst", 1'b1, intN);
        cmpBit("chargeRst", 1'b0, chargeEnable);
        sysRst = 1'b0;
        waitCyc(6);
        cmpBit("charge", 1'b1, chargeEnable);
        cmpBit("rail", 1'b1, railEnable);
        // Ordinary flags: rise sets, fall does nothing, read clears
        for (int i = 0; i < 10; i++) begin
            b = rows[i].pos;
            expFlags = '0;
            expFlags[b] = 1'b1;
            statusRaw[b] = 1'b1;
            waitCyc(5);
            cmpVec("flagSet", expFlags, flags);
            cmpBit("intNLow", 1'b0, intN);
            cmpBit("charge", rows[i].ce, chargeEnable);
            cmpBit("timerRun", rows[i].run, timerRun);
            cmpBit("vregReduced", rows[i].vr, vregReduced);
            if (b < 2)
                cmpBit("railFromInput", 1'b1, railFromInput);
            waitCyc(PULSE);
            cmpBit("intNHigh", 1'b1, intN);
            statusRaw[b] = 1'b0;
            waitCyc(5);
            cmpBit("intNFall", 1'b1, intN);
            cmpVec("flagHeld", expFlags, flags);
            hostRead();
            cmpVec("readFlags", expFlags, readFlags);
            cmpVec("flagClear", 15'h0000, flags);
            cmpBit("chargeBack", 1'b1, chargeEnable);
        end
        // Interrupt pulse width for a thermistor fault
        statusRaw[FLG_TH_OPEN] = 1'b1;
        cnt = 0;
        while (intN !== 1'b0 && cnt < 10) begin
            waitCyc(1);
            cnt++;
        end
        if (cnt >= 10) begin
            cmpBit("intNStart", 1'b0, intN);
            complete_run();
        end
        cnt = 0;
        while (intN === 1'b0 && cnt < 40) begin
            waitCyc(1);
            cnt++;
        end
        cmpBit("pulseWidth", 1'b1, cnt == PULSE);
        statusRaw[FLG_TH_OPEN] = 1'b0;
        hostRead();
        // Safety timer fault survives a read, clears on input toggle
        statusRaw[FLG_TIMER] = 1'b1;
        waitCyc(5);
        cmpBit("timerFlag", 1'b1, flags[FLG_TIMER]);
        cmpBit("chargeOff", 1'b0, chargeEnable);
        cmpBit("railFromInput", 1'b1, railFromInput);
        statusRaw[FLG_TIMER] = 1'b0;
        hostRead();
        cmpBit("timerFlagKept", 1'b1, flags[FLG_TIMER]);
        vinValid = 1'b0;
        seen = 1'b0;
        for (int k = 0; k < 8; k++) begin
            waitCyc(1);
            if (timerReset === 1'b1)
                seen = 1'b1;
        end
        cmpBit("timerReset", 1'b1, seen);
        cmpBit("timerFlagGone", 1'b0, flags[FLG_TIMER]);
        vinValid = 1'b1;
        waitCyc(5);
        cmpBit("chargeResumed", 1'b1, chargeEnable);
        // Button held past the first wake time only, then past all
        buttonN = 1'b0;
        waitCyc(45);
        buttonN = 1'b1;
        waitCyc(5);
        cmpVec("wakeFirst", 15'h1000, flags);
        hostRead();
        buttonN = 1'b0;
        waitCyc(110);
        buttonN = 1'b1;
        waitCyc(5);
        cmpVec("wakeAll", 15'h7000, flags);
        hostRead();
        // Overcurrent leaves the regulator to the host
        regOn = 1'b1;
        waitCyc(4);
        statusRaw[FLG_OCP] = 1'b1;
        waitCyc(5);
        cmpBit("regulatorOn", 1'b1, regulatorEnable);
        statusRaw[FLG_OCP] = 1'b0;
        hostRead();
        waitCyc(PULSE);
        cmpBit("regulatorOff", 1'b0, regulatorEnable);
        // Die shutdown turns off charge, timer, regulator and rail without a flag
        regOn = 1'b0;
        waitCyc(2);
        regOn = 1'b1;
        dieOt = 1'b1;
        waitCyc(6);
        cmpVec("shutFlags", 15'h0000, flags);
        cmpBit("shutIntN", 1'b1, intN);
        cmpBit("shutCharge", 1'b0, chargeEnable);
        cmpBit("shutTimer", 1'b0, timerRun);
        cmpBit("shutReg", 1'b0, regulatorEnable);
        cmpBit("shutRail", 1'b0, railEnable);
        dieOt = 1'b0;
        regOn = 1'b0;
        // Open cap pin keeps charging off until reset
        statusRaw[FLG_CAP_PIN_OPEN] = 1'b1;
        waitCyc(5);
        statusRaw[FLG_CAP_PIN_OPEN] = 1'b0;
        hostRead();
        waitCyc(5);
        cmpBit("capCharge", 1'b0, chargeEnable);
        sysRst = 1'b1;
        waitCyc(2);
        sysRst = 1'b0;
        waitCyc(6);
        cmpBit("capReset", 1'b1, chargeEnable);
        complete_run();
    end
endmodule : cffr_flag_response_tb

// ---- cffr_host_model.sv ----
`timescale 1ns/1ns
// ----------------------------------------
// Host reading flags over the serial bus
// ----------------------------------------
module cffr_host_model
    import cffr_pkg::*;
(
    // Clock and reset
    input wire logic clk_sys,
    input wire logic sys_rst,
    // Bench requests
    input wire logic readReq,
    input wire logic regOn,
    // Device side
    input wire logic [FLAG_W-1:0] flags,
    output logic hostReadClear,
    output logic regulatorEnableReq,
    output logic [FLAG_W-1:0] readFlags
);
    logic clear_q, clear_d, req_q, req_d, ocp_q, ocp_d;
    logic [FLAG_W-1:0] seen_q, seen_d;

    always_comb begin
        // One read pulse per request, flags taken at the clearing edge
        clear_d = readReq & ~clear_q;
        seen_d = clear_q ? flags : seen_q;
        // Device keeps the regulator on, so the host drops it itself
        ocp_d = regOn & (ocp_q | (clear_q & flags[FLG_OCP]));
        req_d = regOn & ~ocp_d;
    end

    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            clear_q <= 1'b0;
            req_q <= 1'b0;
            ocp_q <= 1'b0;
            seen_q <= '0;
        end else begin
            clear_q <= clear_d;
            req_q <= req_d;
            ocp_q <= ocp_d;
            seen_q <= seen_d;
        end
    end

    assign hostReadClear = clear_q;
    assign regulatorEnableReq = req_q;
    assign readFlags = seen_q;
endmodule : cffr_host_model

// ---- cffr_pkg.sv ----
// ---------------------------------------------------------------
// Flag layout, timing and reset values
// ---------------------------------------------------------------
package cffr_pkg;

    localparam int STAT_W = 12;
    localparam int FLAG_W = 15;
    localparam int MISC_W = 4;

    // Flag bit positions
    localparam int FLG_WARM = 0;
    localparam int FLG_HOT = 1;
    localparam int FLG_ADC_READY = 2;
    localparam int FLG_CMP_ONE = 3;
    localparam int FLG_CMP_TWO = 4;
    localparam int FLG_CMP_THREE = 5;
    localparam int FLG_CAP_ACTIVE = 6;
    localparam int FLG_TH_OPEN = 7;
    localparam int FLG_WDOG = 8;
    localparam int FLG_TIMER = 9;
    localparam int FLG_OCP = 10;
    localparam int FLG_CAP_PIN_OPEN = 11;
    localparam int FLG_WAKE_ONE = 12;
    localparam int FLG_WAKE_TWO = 13;
    localparam int FLG_RESET_WARN = 14;

    // Positions in the miscellaneous input group
    localparam int MSC_BUTTON_N = 0;
    localparam int MSC_VIN = 1;
    localparam int MSC_CE_N = 2;
    localparam int MSC_DIE_OT = 3;

    // Clock and times
    localparam int CLK_PERIOD_NS = 8;
    localparam int INT_PULSE_NS = 128000;
    localparam int INT_PULSE_CYC = INT_PULSE_NS / CLK_PERIOD_NS;
    localparam int FIRST_WAKE_US = 1000;
    localparam int SECOND_WAKE_US = 2000;
    localparam int RESET_WARN_US = 4000;
    localparam int FIRST_WAKE_CYC = FIRST_WAKE_US * 1000 / CLK_PERIOD_NS;
    localparam int SECOND_WAKE_CYC = SECOND_WAKE_US * 1000 / CLK_PERIOD_NS;
    localparam int RESET_WARN_CYC = RESET_WARN_US * 1000 / CLK_PERIOD_NS;
    localparam int CNT_W = 24;

    // Reset values
    localparam logic [FLAG_W-1:0] FLAGS_RST = 15'h0000;
    localparam logic [CNT_W-1:0] CNT_RST = 24'h000000;
    // Idle pin levels: button released, input valid, enable low, die cool.
    // A missing input at reset only shows as a harmless toggle.
    localparam logic [MISC_W-1:0] MISC_RST = 4'h3;

endpackage : cffr_pkg

// ---- cffr_sync_edge.sv ----
`timescale 1ns/1ns
module cffr_sync_edge #(
    parameter int W = 1,
    // Reset to the idle level so no false edge follows reset
    parameter logic [W-1:0] RST_VAL = '0
) (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic sys_rst,
    // Raw asynchronous inputs
    input wire logic [W-1:0] rawIn,
    // Synchronised level and edges
    output logic [W-1:0] level,
    output logic [W-1:0] rise,
    output logic [W-1:0] fall
);

    logic [W-1:0] meta_q, meta_d;
    logic [W-1:0] sync_q, sync_d;
    logic [W-1:0] prev_q, prev_d;

    // First stage is read only by the second
    always_comb begin
        meta_d = rawIn;
        sync_d = meta_q;
        prev_d = sync_q;
    end

    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            meta_q <= RST_VAL;
            sync_q <= RST_VAL;
            prev_q <= RST_VAL;
        end else begin
            meta_q <= meta_d;
            sync_q <= sync_d;
            prev_q <= prev_d;
        end
    end

    assign level = sync_q;
    assign rise = sync_q & ~prev_q;
    assign fall = ~sync_q & prev_q;

endmodule : cffr_sync_edge
